// ==== rtl/mivr_pkg.sv ====
// Constants and types shared by the MAC interrupt vector block.
// Assumes a 32-bit APB slave port with byte addresses on paddr.
package mivr_pkg;

	// Register map, byte addresses of aligned words
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_VECTOR    = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RX_RAW    = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_RX_MASKED = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_RX_EN_SET = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_RX_EN_CLR = 8'h10;
	localparam logic [1:0]        ADDR_ALIGN     = 2'h0;

	localparam int unsigned DATA_W  = 32;
	localparam int unsigned CHAN_N  = 8;

	// Source vector field positions
	localparam int unsigned VEC_USER_BIT  = 31;
	localparam int unsigned VEC_LINK_BIT  = 30;
	localparam int unsigned VEC_RSV_HI    = 29;
	localparam int unsigned VEC_RSV_LO    = 18;
	localparam int unsigned VEC_HOST_BIT  = 17;
	localparam int unsigned VEC_STAT_BIT  = 16;
	localparam int unsigned VEC_RX_LO     = 8;
	localparam int unsigned VEC_TX_LO     = 0;

	// Reset values
	localparam logic [DATA_W-1:0] RST_DATA   = 32'h0000_0000;
	localparam logic [CHAN_N-1:0] RST_CHAN   = 8'h00;
	localparam logic [CHAN_N-1:0] ALL_CHAN   = 8'hff;

	typedef enum logic {
		PH_IDLE,
		PH_ACCESS
	} mivr_phase_e;

	typedef logic [CHAN_N-1:0] mivr_chan_t;

endpackage

// ==== rtl/mivr_en_if.sv ====
// Link between the register front end and the receive enable bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mivr_en_if #(
	parameter int unsigned N = mivr_pkg::CHAN_N
);
	logic [N-1:0] setBits;
	logic [N-1:0] clrBits;
	logic [N-1:0] raw;
	logic [N-1:0] enable;
	logic [N-1:0] masked;

	modport bank (
		input  setBits,
		input  clrBits,
		input  raw,
		output enable,
		output masked
	);

	modport ctrl (
		output setBits,
		output clrBits,
		output raw,
		input  enable,
		input  masked
	);
endinterface

// ==== rtl/mivr_enable_bank.sv ====
// Receive channel enable bits with set and clear strobes.
// Assumes strobes are one-cycle pulses from the register front end.
`timescale 1ns/1ps
module mivr_enable_bank #(
	parameter int unsigned N = mivr_pkg::CHAN_N
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic ce,
	mivr_en_if.bank   en
);

	typedef struct packed {
		logic [N-1:0] enable;
	} mivr_bank_s;

	mivr_bank_s s_q;
	mivr_bank_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.enable = s_d.enable & ~en.clrBits;
		s_d.enable = s_d.enable | en.setBits;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q.enable <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign en.enable = s_q.enable;
	assign en.masked = en.raw & s_q.enable;

endmodule

// ==== rtl/mivr_top.sv ====
// MAC interrupt source vector and receive channel status/enable registers.
// Assumes all interrupt source inputs come from logic on the same clock
// and a standard APB master with 32-bit data on the register port.
//
// Summary of operation
// - Source vector bit 31 shows the serial unit user-access interrupt.
// - Source vector bit 30 shows the serial unit link-change interrupt.
// - Source vector bit 17 shows the MAC host-error interrupt.
// - Source vector bit 16 shows the MAC statistics interrupt.
// - Source vector bits 15 to 8 show receive channels 0 to 7 pending.
// - Source vector bits 7 to 0 show transmit channels 0 to 7 pending.
// - Source vector bits 29 to 18 always read zero.
// - Raw receive status bits 7 to 0 show each channel before masking.
// - Masked receive status bits 7 to 0 show each channel after masking.
// - A one written to the enable-set register enables that channel.
// - Receive enables reset to zero and read back through the set register.
// - Bits 31 to 8 of the receive registers read zero and ignore writes.
// - A one written to the enable-clear register disables that channel.
`timescale 1ns/1ps
module mivr_top #(
	parameter int unsigned N = mivr_pkg::CHAN_N
) (
	input  wire logic                          clock,
	input  wire logic                          nrst,
	input  wire logic                          ce,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [mivr_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [mivr_pkg::DATA_W-1:0]   pwdata,
	output logic      [mivr_pkg::DATA_W-1:0]   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          mgmtUserAccessIrq,
	input  wire logic                          mgmtLinkChangeIrq,
	input  wire logic                          hostErrorPending,
	input  wire logic                          statsPending,
	input  wire logic [N-1:0]                  rxChannelPendingBit,
	input  wire logic [N-1:0]                  txChannelsPending,
	output logic      [N-1:0]                  rxChannelsPending,
	output logic      [N-1:0]                  rxChannelEnableBit
);

	typedef struct packed {
		mivr_pkg::mivr_phase_e       phase;
		logic                        ready;
		logic                        slvErr;
		logic [mivr_pkg::DATA_W-1:0] rdata;
		logic                        userIrq;
		logic                        linkIrq;
		logic                        host_error_pending;
		logic                        stats_pending;
		logic [N-1:0]                rxRaw;
		logic [N-1:0]                tx_channels_pending;
		logic [N-1:0]                rxMaskedOut;
		logic [N-1:0]                rxEnableOut;
	} mivr_top_s;

	mivr_top_s s_q;
	mivr_top_s s_d;

	mivr_en_if #(.N(N)) enLink ();

	mivr_enable_bank #(
		.N(N)
	) u_bank (
		.clock(clock),
		.nrst (nrst),
		.ce   (ce),
		.en   (enLink)
	);

	logic                        setupCycle;
	logic                        accessDone;
	logic                        addrAligned;
	logic                        addrKnown;
	logic                        doWrite;
	logic [mivr_pkg::DATA_W-1:0] vectorWord;
	logic [mivr_pkg::DATA_W-1:0] rawWord;
	logic [mivr_pkg::DATA_W-1:0] maskedWord;
	logic [mivr_pkg::DATA_W-1:0] enableWord;
	logic [mivr_pkg::DATA_W-1:0] readWord;
	logic [N-1:0]                setStrobe;
	logic [N-1:0]                clrStrobe;

	// Bus phase tracking
	assign setupCycle = psel && !penable && (s_q.phase == mivr_pkg::PH_IDLE);
	assign accessDone = psel && penable && s_q.ready;
	assign addrAligned = (paddr[1:0] == mivr_pkg::ADDR_ALIGN);

	always_comb begin
		addrKnown = 1'b0;
		if (addrAligned) begin
			case (paddr)
				mivr_pkg::ADDR_VECTOR,
				mivr_pkg::ADDR_RX_RAW,
				mivr_pkg::ADDR_RX_MASKED,
				mivr_pkg::ADDR_RX_EN_SET,
				mivr_pkg::ADDR_RX_EN_CLR: begin
					addrKnown = 1'b1;
				end
				default: begin
					addrKnown = 1'b0;
				end
			endcase
		end
	end

	assign doWrite = accessDone && pwrite && !s_q.slvErr;

	// Source vector assembly
	always_comb begin
		vectorWord = mivr_pkg::RST_DATA;
		vectorWord[mivr_pkg::VEC_USER_BIT] = s_q.userIrq;
		vectorWord[mivr_pkg::VEC_LINK_BIT] = s_q.linkIrq;
		vectorWord[mivr_pkg::VEC_RSV_HI:mivr_pkg::VEC_RSV_LO] = '0;
		vectorWord[mivr_pkg::VEC_HOST_BIT] = s_q.host_error_pending;
		vectorWord[mivr_pkg::VEC_STAT_BIT] = s_q.stats_pending;
		vectorWord[mivr_pkg::VEC_RX_LO +: N] = enLink.masked;
		vectorWord[mivr_pkg::VEC_TX_LO +: N] = s_q.tx_channels_pending;
	end

	// Receive register words, upper bits zero
	always_comb begin
		rawWord    = mivr_pkg::RST_DATA;
		maskedWord = mivr_pkg::RST_DATA;
		enableWord = mivr_pkg::RST_DATA;
		rawWord[N-1:0] = s_q.rxRaw;
		maskedWord[N-1:0] = enLink.masked;
		enableWord[N-1:0] = enLink.enable;
	end

	// Read multiplexer
	always_comb begin
		readWord = mivr_pkg::RST_DATA;
		case (paddr)
			mivr_pkg::ADDR_VECTOR: begin
				readWord = vectorWord;
			end
			mivr_pkg::ADDR_RX_RAW: begin
				readWord = rawWord;
			end
			mivr_pkg::ADDR_RX_MASKED: begin
				readWord = maskedWord;
			end
			mivr_pkg::ADDR_RX_EN_SET,
			mivr_pkg::ADDR_RX_EN_CLR: begin
				readWord = enableWord;
			end
			default: begin
				readWord = mivr_pkg::RST_DATA;
			end
		endcase
		if (!addrAligned) begin
			readWord = mivr_pkg::RST_DATA;
		end
	end

	// Write strobes toward the enable bank
	always_comb begin
		setStrobe = '0;
		clrStrobe = '0;
		if (doWrite) begin
			case (paddr)
				mivr_pkg::ADDR_RX_EN_SET: begin
					setStrobe = pwdata[N-1:0];
				end
				mivr_pkg::ADDR_RX_EN_CLR: begin
					clrStrobe = pwdata[N-1:0];
				end
				default: begin
					setStrobe = '0;
					clrStrobe = '0;
				end
			endcase
		end
	end

	assign enLink.setBits = setStrobe;
	assign enLink.clrBits = clrStrobe;
	assign enLink.raw     = s_q.rxRaw;

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.userIrq     = mgmtUserAccessIrq;
		s_d.linkIrq     = mgmtLinkChangeIrq;
		s_d.host_error_pending    = hostErrorPending;
		s_d.stats_pending    = statsPending;
		s_d.rxRaw       = rxChannelPendingBit;
		s_d.tx_channels_pending      = txChannelsPending;
		s_d.rxMaskedOut = enLink.masked;
		s_d.rxEnableOut = enLink.enable;
		case (s_q.phase)
			mivr_pkg::PH_IDLE: begin
				s_d.ready = 1'b0;
				if (setupCycle) begin
					s_d.phase  = mivr_pkg::PH_ACCESS;
					s_d.ready  = 1'b1;
					s_d.slvErr = !addrKnown;
					s_d.rdata  = pwrite ? mivr_pkg::RST_DATA : readWord;
				end
			end
			mivr_pkg::PH_ACCESS: begin
				// Zero-wait answer, one access cycle
				s_d.phase  = mivr_pkg::PH_IDLE;
				s_d.ready  = 1'b0;
				s_d.slvErr = 1'b0;
				s_d.rdata  = mivr_pkg::RST_DATA;
			end
			default: begin
				s_d.phase  = mivr_pkg::PH_IDLE;
				s_d.ready  = 1'b0;
				s_d.slvErr = 1'b0;
				s_d.rdata  = mivr_pkg::RST_DATA;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q.phase       <= mivr_pkg::PH_IDLE;
			s_q.ready       <= 1'b0;
			s_q.slvErr      <= 1'b0;
			s_q.rdata       <= mivr_pkg::RST_DATA;
			s_q.userIrq     <= 1'b0;
			s_q.linkIrq     <= 1'b0;
			s_q.host_error_pending    <= 1'b0;
			s_q.stats_pending    <= 1'b0;
			s_q.rxRaw       <= '0;
			s_q.tx_channels_pending      <= '0;
			s_q.rxMaskedOut <= '0;
			s_q.rxEnableOut <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign prdata             = s_q.rdata;
	assign pready             = s_q.ready;
	assign pslverr            = s_q.slvErr;
	assign rxChannelsPending  = s_q.rxMaskedOut;
	assign rxChannelEnableBit = s_q.rxEnableOut;

endmodule

// ==== test/mivr_properties.sv ====
// Concurrent checks on the ports of mivr_top.
// Assumes one clock domain; bound to mivr_top at the foot of this file.
`timescale 1ns/1ps
module mivr_properties #(
	parameter int unsigned N = 8
) (
	input wire logic         clock,
	input wire logic         nrst,
	input wire logic         pwrite,
	input wire logic [7:0]   paddr,
	input wire logic [31:0]  pwdata,
	input wire logic [31:0]  prdata,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic         mgmtUserAccessIrq,
	input wire logic         mgmtLinkChangeIrq,
	input wire logic         hostErrorPending,
	input wire logic         statsPending,
	input wire logic [N-1:0] rxChannelPendingBit,
	input wire logic [N-1:0] txChannelsPending,
	input wire logic [N-1:0] rxChannelsPending,
	input wire logic [N-1:0] rxChannelEnableBit
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	wire logic [3:0] src = {mgmtUserAccessIrq, mgmtLinkChangeIrq,
		hostErrorPending, statsPending};
	wire logic rdv = pready && !pwrite && !pslverr;
	wire logic wrv = pready && pwrite && !pslverr;

	a_mask_gate: assert property (
		(rxChannelsPending & ~rxChannelEnableBit) == '0)
		else $error("masked rx bit set on disabled channel");
	a_vec_reserved: assert property (
		rdv && paddr == 8'h00 |-> prdata[29:18] == 12'h000)
		else $error("vector gap not zero");
	a_rx_upper: assert property (
		rdv && paddr inside {8'h04, 8'h08, 8'h0c} |-> prdata[31:8] == 24'h0)
		else $error("rx upper bits set");
	a_vec_sources: assert property (
		rdv && paddr == 8'h00 && $past(src) == src && $past(src, 2) == src
		|-> {prdata[31:30], prdata[17:16]} == src)
		else $error("vector source bits wrong");
	a_vec_tx: assert property (
		rdv && paddr == 8'h00 && $stable(txChannelsPending) &&
		$past(txChannelsPending, 2) == txChannelsPending
		|-> prdata[7:0] == txChannelsPending)
		else $error("vector tx field wrong");
	a_raw_view: assert property (
		rdv && paddr == 8'h04 && $stable(rxChannelPendingBit) &&
		$past(rxChannelPendingBit, 2) == rxChannelPendingBit
		|-> prdata[7:0] == rxChannelPendingBit)
		else $error("raw rx read wrong");
	a_en_reset: assert property (
		$rose(nrst) |-> rxChannelEnableBit == '0)
		else $error("enables not cleared by reset");
	a_en_set: assert property (
		wrv && paddr == 8'h0c |-> ##2 (rxChannelEnableBit &
		$past(pwdata[7:0], 2)) == $past(pwdata[7:0], 2))
		else $error("set write did not enable");
	a_en_clear: assert property (
		wrv && paddr == 8'h10 |-> ##2 (rxChannelEnableBit &
		$past(pwdata[7:0], 2)) == 8'h00)
		else $error("clear write did not disable");
endmodule

bind mivr_top mivr_properties #(.N(N)) mivr_properties_inst (
	.clock(clock), .nrst(nrst), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mgmtUserAccessIrq(mgmtUserAccessIrq),
	.mgmtLinkChangeIrq(mgmtLinkChangeIrq),
	.hostErrorPending(hostErrorPending), .statsPending(statsPending),
	.rxChannelPendingBit(rxChannelPendingBit),
	.txChannelsPending(txChannelsPending),
	.rxChannelsPending(rxChannelsPending),
	.rxChannelEnableBit(rxChannelEnableBit));

// ==== test/mac_interrupt_vector_rx_mask_tb.sv ====
// Self-checking bench for mivr_top over its APB register port.
// Assumes the register map of mivr_pkg and a slave that answers in time.
`timescale 1ns/1ps
module mac_interrupt_vector_rx_mask_tb;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        userIrq = 1'b0;
	logic        linkIrq = 1'b0;
	logic        hostErr = 1'b0;
	logic        statIrq = 1'b0;
	logic [7:0]  rxRaw = 8'h00;
	logic [7:0]  tx_channels_pending = 8'h00;
	logic [7:0]  en = 8'h00;
	logic        ce = 1'b1;
	logic [7:0]  rxPendOut;
	logic [7:0]  rxEnOut;
	logic [31:0] rd;
	logic        err;
	int          err_total = 0;
	int          checks = 0;

	always #12.5 clock = ~clock;

	mivr_top mivr_top_inst (.clock(clock), .nrst(nrst), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mgmtUserAccessIrq(userIrq),
		.mgmtLinkChangeIrq(linkIrq), .hostErrorPending(hostErr),
		.statsPending(statIrq), .rxChannelPendingBit(rxRaw),
		.txChannelsPending(tx_channels_pending), .rxChannelsPending(rxPendOut),
		.rxChannelEnableBit(rxEnOut));

	task automatic finish_test();
		if (err_total == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			chk("pready", 32'h1, 32'h0);
			finish_test();
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task automatic src(input logic [3:0] s, input logic [7:0] r,
		input logic [7:0] t);
		@(posedge clock);
		{userIrq, linkIrq, hostErr, statIrq} <= s;
		rxRaw <= r;
		tx_channels_pending <= t;
		repeat (2) @(posedge clock);
	endtask

	// Registered pending and enable outputs against the model
	task automatic outs();
		chk("rxChannelsPending", {24'h0, rxRaw & en}, {24'h0, rxPendOut});
		chk("rxChannelEnableBit", {24'h0, en}, {24'h0, rxEnOut});
	endtask

	function automatic logic [31:0] vexp();
		return {userIrq, linkIrq, 12'h000, hostErr, statIrq, rxRaw & en,
			tx_channels_pending};
	endfunction

	initial begin
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		rdchk(8'h0c, 32'h0, "enable");
		rdchk(8'h08, 32'h0, "masked");
		outs();
		src(4'b1010, 8'ha5, 8'h3c);
		rdchk(8'h04, 32'h0000_00a5, "raw");
		rdchk(8'h00, vexp(), "vector");
		apb(1'b1, 8'h0c, 32'hffff_ff0f);
		chk("prdata", 32'h0, rd);
		en = 8'h0f;
		rdchk(8'h0c, 32'h0000_000f, "enable");
		apb(1'b1, 8'h0c, 32'h0);
		rdchk(8'h0c, 32'h0000_000f, "enable");
		rdchk(8'h08, 32'h0000_0005, "masked");
		outs();
		src(4'b0101, 8'h5a, 8'hc3);
		rdchk(8'h00, vexp(), "vector");
		apb(1'b1, 8'h10, 32'hffff_ff03);
		en = 8'h0c;
		rdchk(8'h0c, 32'h0000_000c, "enable");
		apb(1'b1, 8'h10, 32'h0);
		rdchk(8'h08, 32'h0000_0008, "masked");
		outs();
		apb(1'b1, 8'h04, 32'hffff_ffff);
		rdchk(8'h04, 32'h0000_005a, "raw");
		rdchk(8'h00, vexp(), "vector");
		// Clock enable low freezes the registered outputs
		@(posedge clock);
		ce <= 1'b0;
		rxRaw <= 8'hff;
		repeat (3) @(posedge clock);
		chk("frozen pending", 32'h0000_0008, {24'h0, rxPendOut});
		ce <= 1'b1;
		repeat (3) @(posedge clock);
		outs();
		apb(1'b0, 8'h14, 32'h0);
		chk("pslverr", 32'h1, {31'h0, err});
		chk("prdata", 32'h0, rd);
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		rdchk(8'h0c, 32'h0, "enable");
		en = 8'h00;
		outs();
		finish_test();
	end
endmodule
